// ---- ctaio_pkg.sv ----
// ctaio_pkg: shared constants and types of the calibration trigger and alarm io block
// assumes a single 100 MHz system clock and an ahb-lite register bus with 32-bit data
package ctaio_pkg;

	// ----------------------------------------------------------------
	// channel counts and widths
	// ----------------------------------------------------------------
	localparam int unsigned NUM_DIN   = 8;           // discrete input channels
	localparam int unsigned NUM_DOUT  = 8;           // discrete output channels
	localparam int unsigned NUM_AO    = 3;           // analog outputs watched for overscale
	localparam int unsigned SEL_W     = 5;           // output status selector width
	localparam int unsigned NUM_FAULT = 10;          // individual fault statuses

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DIN_CFG  = 8'h00;     // input action and polarity, nibble per channel
	localparam logic [7:0] OFS_DOUT_LO  = 8'h04;     // output select, channels 0..3, byte each
	localparam logic [7:0] OFS_DOUT_HI  = 8'h08;     // output select, channels 4..7, byte each
	localparam logic [7:0] OFS_CTRL     = 8'h0C;     // calibration mode, maintenance, overscale enables
	localparam logic [7:0] OFS_STATUS   = 8'h10;     // read-only live state

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned DIN_ACT_LSB  = 0;        // 2-bit action code in each nibble
	localparam int unsigned DIN_POL_BIT  = 2;        // 1 = active high
	localparam int unsigned DOUT_SEL_LSB = 0;        // 5-bit selector in each byte
	localparam int unsigned DOUT_POL_BIT = 5;        // 1 = active high
	localparam int unsigned CTRL_CAL_LSB = 0;        // 2-bit calibration mode
	localparam int unsigned CTRL_MNT_BIT = 2;        // maintenance mode
	localparam int unsigned CTRL_OSE_LSB = 4;        // 3 overscale enables
	localparam int unsigned STS_DIN_LSB  = 0;        // synchronised input levels
	localparam int unsigned STS_DOUT_LSB = 8;        // output pin levels
	localparam int unsigned STS_CAL_LSB  = 16;       // calibration mode
	localparam int unsigned STS_OVS_LSB  = 18;       // overscale flags
	localparam int unsigned STS_SYS_BIT  = 21;       // summary fault

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_DIN_CFG = 32'h4444_4444;   // all disabled, active high
	localparam logic [31:0] RST_DOUT    = 32'h2020_2020;   // all disabled, active high
	localparam logic [2:0]  RST_OSE     = 3'h0;            // overscale off

	// ----------------------------------------------------------------
	// overscale thresholds in percent of standard range
	// ----------------------------------------------------------------
	localparam logic [7:0] OVS_ENTER_PCT = 8'h5A;    // 90 percent
	localparam logic [7:0] OVS_LEAVE_PCT = 8'h50;    // 80 percent

	// ----------------------------------------------------------------
	// output status selector codes
	// ----------------------------------------------------------------
	localparam logic [4:0] ST_DISABLED = 5'h00;
	localparam logic [4:0] ST_FAULT0   = 5'h01;      // codes 1..10 are the fault bits in order
	localparam logic [4:0] ST_USB_OUT  = 5'h0B;
	localparam logic [4:0] ST_BKGND    = 5'h0C;
	localparam logic [4:0] ST_SPAN     = 5'h0D;
	localparam logic [4:0] ST_ZERO     = 5'h0E;
	localparam logic [4:0] ST_SYSFLT   = 5'h0F;
	localparam logic [4:0] ST_MAINT    = 5'h10;
	localparam logic [4:0] ST_OVS0     = 5'h11;      // codes 17..19 are the analog overscale flags
	localparam logic [4:0] ST_LAST     = 5'h13;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ACT_NONE, ACT_SPAN, ACT_ZERO} ctaio_act_t;   // input action
	typedef enum logic [1:0] {CAL_MEASURE, CAL_SPAN, CAL_ZERO} ctaio_cal_t; // calibration mode

	// fault statuses, bit order is selector order
	typedef struct packed {
		logic chassis_temp;
		logic lamp_heat;
		logic mirror_heat;
		logic flow_block_heat;
		logic scrubber_heat;
		logic cell_heat;
		logic sample_flow;
		logic corr_wheel;
		logic converter_fault;
		logic power_supply;
	} ctaio_faults_t;

	// analog output levels, percent of the standard range
	typedef struct packed {
		logic [7:0] ch2;
		logic [7:0] ch1;
		logic [7:0] ch0;
	} ctaio_ao_level_t;

endpackage

// ---- ctaio_top.sv ----
// ctaio_top: discrete calibration triggers and alarm outputs behind an ahb-lite slave
// assumes hready is the slave's own hreadyout, status inputs come from same-clock logic,
// and the discrete input pins are asynchronous to CLOCK_IN
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - eight inputs, each with own action
// - act when input enters active level
// - disabled input has no effect
// - span action sets calibration mode span
// - zero action sets calibration mode zero
// - per-input polarity, high or low active
// - eight outputs, each selects one status
// - output active while selected status true
// - per-output polarity, high or low active
// - disabled output never reaches active level
// - ten fault statuses are selectable
// - status true while storage stick absent
// - background, span, zero in progress statuses
// - summary status true on any fault
// - status true while maintenance mode on
// - three analog output overscale statuses
// - enter overscale at 90, leave 80
module ctaio_top (
	// clock and reset
	input  wire logic                       CLOCK_IN,
	input  wire logic                       RST_IN,
	// ahb-lite slave
	input  wire logic                       HSEL_IN,
	input  wire logic [31:0]                HADDR_IN,
	input  wire logic [1:0]                 HTRANS_IN,
	input  wire logic                       HWRITE_IN,
	input  wire logic [2:0]                 HSIZE_IN,
	input  wire logic [31:0]                HWDATA_IN,
	input  wire logic                       HREADY_IN,
	output logic      [31:0]                HRDATA_OUT,
	output logic                            HREADYOUT_OUT,
	output logic                            HRESP_OUT,
	// instrument status from same-clock logic
	input  wire ctaio_pkg::ctaio_faults_t   FAULT_IN,
	input  wire logic                       USB_ABSENT_IN,
	input  wire logic                       BACKGROUND_IN,
	input  wire ctaio_pkg::ctaio_ao_level_t AO_LEVEL_IN,
	// discrete pins
	input  wire logic [7:0]                 DIN_IN,
	output logic      [7:0]                 DOUT_OUT,
	// calibration mode to the instrument
	output logic      [1:0]                 CAL_MODE_OUT
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [31:0]           din_cfg_r;     // input configuration
	logic [63:0]           dout_cfg_r;    // output configuration
	logic                  maint_r;       // maintenance mode
	logic [2:0]            ose_r;         // overscale enables
	ctaio_pkg::ctaio_cal_t cal_r;         // calibration mode
	logic [2:0]            ovs_r;         // overscale flags
	logic [19:0]           stat_vec;      // status by selector code
	logic [7:0]            din_s1_r;      // first synchroniser stage
	logic [7:0]            din_s2_r;      // second synchroniser stage
	logic [7:0]            din_act;       // polarity-corrected active level
	logic [7:0]            din_act_r;     // previous active level
	logic [7:0]            din_rise;      // entry into active level
	logic [7:0]            req_span;      // span request per channel
	logic [7:0]            req_zero;      // zero request per channel

	// ----------------------------------------------------------------
	// ahb-lite slave: zero wait states, always okay
	// ----------------------------------------------------------------
	logic       wr_pend_r;                // write data phase in progress
	logic [7:0] wr_addr_r;                // latched write offset
	logic       addr_ok;                  // valid word access this cycle
	logic       wr_cal;                   // software writes a legal cal mode
	logic [31:0] rd_val;                  // read mux result

	assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1] && (HSIZE_IN == 3'h2);
	assign wr_cal  = wr_pend_r && (wr_addr_r == ctaio_pkg::OFS_CTRL)
		&& (HWDATA_IN[ctaio_pkg::CTRL_CAL_LSB +: 2] != 2'h3);

	// write address phase capture
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok && HWRITE_IN;
			wr_addr_r <= HADDR_IN[7:0];
		end
	end

	// read mux; a write in its data phase to the same offset is forwarded, except to the ctrl and status offsets
	always_comb begin
		rd_val = 32'h0000_0000;
		if (HADDR_IN[7:0] == ctaio_pkg::OFS_DIN_CFG) begin
			rd_val = din_cfg_r;
		end else if (HADDR_IN[7:0] == ctaio_pkg::OFS_DOUT_LO) begin
			rd_val = dout_cfg_r[31:0];
		end else if (HADDR_IN[7:0] == ctaio_pkg::OFS_DOUT_HI) begin
			rd_val = dout_cfg_r[63:32];
		end else if (HADDR_IN[7:0] == ctaio_pkg::OFS_CTRL) begin
			rd_val[ctaio_pkg::CTRL_CAL_LSB +: 2] = cal_r;
			rd_val[ctaio_pkg::CTRL_MNT_BIT]      = maint_r;
			rd_val[ctaio_pkg::CTRL_OSE_LSB +: 3] = ose_r;
		end else if (HADDR_IN[7:0] == ctaio_pkg::OFS_STATUS) begin
			rd_val[ctaio_pkg::STS_DIN_LSB +: 8]  = din_s2_r;
			rd_val[ctaio_pkg::STS_DOUT_LSB +: 8] = DOUT_OUT;
			rd_val[ctaio_pkg::STS_CAL_LSB +: 2]  = cal_r;
			rd_val[ctaio_pkg::STS_OVS_LSB +: 3]  = ovs_r;
			rd_val[ctaio_pkg::STS_SYS_BIT]       = stat_vec[ctaio_pkg::ST_SYSFLT];
		end
		// forwarding keeps back-to-back write then read coherent
		if (wr_pend_r && (wr_addr_r == HADDR_IN[7:0]) && (wr_addr_r != ctaio_pkg::OFS_STATUS)
			&& (wr_addr_r != ctaio_pkg::OFS_CTRL)) begin
			rd_val = HWDATA_IN;
		end
	end

	// read data and handshake, unmapped offsets read zero unless forwarded from a write in its data phase
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			HRDATA_OUT    <= 32'h0000_0000;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
		end else begin
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
			if (addr_ok && !HWRITE_IN) begin
				HRDATA_OUT <= rd_val;
			end
		end
	end

	// configuration registers, committed in the write data phase
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			din_cfg_r  <= ctaio_pkg::RST_DIN_CFG;
			dout_cfg_r <= {ctaio_pkg::RST_DOUT, ctaio_pkg::RST_DOUT};
			maint_r    <= 1'b0;
			ose_r      <= ctaio_pkg::RST_OSE;
		end else if (wr_pend_r) begin
			if (wr_addr_r == ctaio_pkg::OFS_DIN_CFG) begin
				din_cfg_r <= HWDATA_IN;
			end else if (wr_addr_r == ctaio_pkg::OFS_DOUT_LO) begin
				dout_cfg_r[31:0] <= HWDATA_IN;
			end else if (wr_addr_r == ctaio_pkg::OFS_DOUT_HI) begin
				dout_cfg_r[63:32] <= HWDATA_IN;
			end else if (wr_addr_r == ctaio_pkg::OFS_CTRL) begin
				maint_r <= HWDATA_IN[ctaio_pkg::CTRL_MNT_BIT];
				ose_r   <= HWDATA_IN[ctaio_pkg::CTRL_OSE_LSB +: 3];
			end
		end
	end

	// ----------------------------------------------------------------
	// discrete inputs
	// ----------------------------------------------------------------
	// pins are asynchronous, so two stages before any decision
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			din_s1_r  <= 8'h00;
			din_s2_r  <= 8'h00;
			din_act_r <= 8'hFF;
		end else begin
			din_s1_r  <= DIN_IN;
			din_s2_r  <= din_s1_r;
			din_act_r <= din_act;
		end
	end

	// per channel: polarity, edge and action decode
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_din
			ctaio_pkg::ctaio_act_t act;
			assign act = ctaio_pkg::ctaio_act_t'(din_cfg_r[gi*4 + ctaio_pkg::DIN_ACT_LSB +: 2]);
			// a low-active channel sees a driven-low line as active
			assign din_act[gi]  = din_cfg_r[gi*4 + ctaio_pkg::DIN_POL_BIT] ?
				din_s2_r[gi] : !din_s2_r[gi];
			assign din_rise[gi] = din_act[gi] && !din_act_r[gi];
			// disabled or unknown codes request nothing
			assign req_span[gi] = din_rise[gi] && (act == ctaio_pkg::ACT_SPAN);
			assign req_zero[gi] = din_rise[gi] && (act == ctaio_pkg::ACT_ZERO);
		end
	endgenerate

	// calibration mode: a pin request wins over a software write in the same cycle,
	// and zero wins over span so a simultaneous pair leaves a defined result
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			cal_r        <= ctaio_pkg::CAL_MEASURE;
			CAL_MODE_OUT <= 2'h0;
		end else begin
			if (|req_zero) begin
				cal_r        <= ctaio_pkg::CAL_ZERO;
				CAL_MODE_OUT <= ctaio_pkg::CAL_ZERO;
			end else if (|req_span) begin
				cal_r        <= ctaio_pkg::CAL_SPAN;
				CAL_MODE_OUT <= ctaio_pkg::CAL_SPAN;
			end else if (wr_cal) begin
				cal_r        <= ctaio_pkg::ctaio_cal_t'(HWDATA_IN[ctaio_pkg::CTRL_CAL_LSB +: 2]);
				CAL_MODE_OUT <= HWDATA_IN[ctaio_pkg::CTRL_CAL_LSB +: 2];
			end
		end
	end

	// ----------------------------------------------------------------
	// analog output overscale with hysteresis
	// ----------------------------------------------------------------
	logic [23:0] ao_lvl;                  // flat view of the three levels
	assign ao_lvl = AO_LEVEL_IN;

	generate
		for (gi = 0; gi < 3; gi++) begin : g_ovs
			// gap between the two thresholds stops chatter near full scale
			always_ff @(posedge CLOCK_IN) begin
				if (RST_IN || !ose_r[gi]) begin
					ovs_r[gi] <= 1'b0;
				end else if (!ovs_r[gi] && (ao_lvl[gi*8 +: 8] >= ctaio_pkg::OVS_ENTER_PCT)) begin
					ovs_r[gi] <= 1'b1;
				end else if (ovs_r[gi] && (ao_lvl[gi*8 +: 8] <= ctaio_pkg::OVS_LEAVE_PCT)) begin
					ovs_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// status vector indexed by selector code
	// ----------------------------------------------------------------
	always_comb begin
		stat_vec                         = 20'h00000;
		stat_vec[ctaio_pkg::ST_FAULT0 +: 10] = FAULT_IN;
		stat_vec[ctaio_pkg::ST_USB_OUT]  = USB_ABSENT_IN;
		stat_vec[ctaio_pkg::ST_BKGND]    = BACKGROUND_IN;
		stat_vec[ctaio_pkg::ST_SPAN]     = (cal_r == ctaio_pkg::CAL_SPAN);
		stat_vec[ctaio_pkg::ST_ZERO]     = (cal_r == ctaio_pkg::CAL_ZERO);
		stat_vec[ctaio_pkg::ST_SYSFLT]   = |FAULT_IN;
		stat_vec[ctaio_pkg::ST_MAINT]    = maint_r;
		stat_vec[ctaio_pkg::ST_OVS0 +: 3] = ovs_r;
	end

	// ----------------------------------------------------------------
	// discrete outputs
	// ----------------------------------------------------------------
	logic [7:0] dout_true;                // selected status per channel

	generate
		for (gi = 0; gi < 8; gi++) begin : g_dout
			logic [4:0] sel;
			logic       pol;
			assign sel = dout_cfg_r[gi*8 + ctaio_pkg::DOUT_SEL_LSB +: 5];
			assign pol = dout_cfg_r[gi*8 + ctaio_pkg::DOUT_POL_BIT];
			// codes past the list behave as disabled
			assign dout_true[gi] = (sel != ctaio_pkg::ST_DISABLED) && (sel <= ctaio_pkg::ST_LAST)
				&& stat_vec[sel];
			always_ff @(posedge CLOCK_IN) begin
				if (RST_IN) begin
					DOUT_OUT[gi] <= 1'b0;
				end else begin
					DOUT_OUT[gi] <= pol ? dout_true[gi] : !dout_true[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_span_sets;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(|req_span && !(|req_zero)) |=> (CAL_MODE_OUT == 2'h1);
	endproperty
	a_span_sets: assert property (p_span_sets) else $error("span request did not set span");

	property p_zero_sets;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(|req_zero) |=> (cal_r == ctaio_pkg::CAL_ZERO) && (CAL_MODE_OUT == 2'h2);
	endproperty
	a_zero_sets: assert property (p_zero_sets) else $error("zero request did not set zero");

	property p_one_request;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		din_rise[0] |=> !din_rise[0];
	endproperty
	a_one_request: assert property (p_one_request) else $error("input edge repeated");

	property p_pin_to_edge;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		$rose(din_s2_r[0]) && din_cfg_r[2] && $stable(din_cfg_r) |-> din_rise[0];
	endproperty
	a_pin_to_edge: assert property (p_pin_to_edge) else $error("active-high edge missed");

	property p_disabled_quiet;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(din_cfg_r[1:0] == 2'h0) |-> !req_span[0] && !req_zero[0];
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled input acted");

	property p_out_follows;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(dout_cfg_r[4:0] == ctaio_pkg::ST_MAINT) && dout_cfg_r[5] && $stable(dout_cfg_r)
			|=> (DOUT_OUT[0] == $past(maint_r));
	endproperty
	a_out_follows: assert property (p_out_follows) else $error("output not following status");

	property p_out_low_active;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(dout_cfg_r[12:8] == ctaio_pkg::ST_SYSFLT) && !dout_cfg_r[13] && (|FAULT_IN)
			|=> !DOUT_OUT[1];
	endproperty
	a_out_low_active: assert property (p_out_low_active) else $error("low-active alarm not low");

	property p_disabled_out;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(dout_cfg_r[4:0] == ctaio_pkg::ST_DISABLED) ##1 (dout_cfg_r[4:0] == ctaio_pkg::ST_DISABLED)
			|-> (DOUT_OUT[0] != $past(dout_cfg_r[5]));
	endproperty
	a_disabled_out: assert property (p_disabled_out) else $error("disabled output went active");

	property p_ovs_band;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		ose_r[1] && $past(ose_r[1]) && (ao_lvl[15:8] > ctaio_pkg::OVS_LEAVE_PCT)
			&& (ao_lvl[15:8] < ctaio_pkg::OVS_ENTER_PCT) && $stable(ao_lvl[15:8])
			|=> $stable(ovs_r[1]);
	endproperty
	a_ovs_band: assert property (p_ovs_band) else $error("overscale moved inside band");

	// entry threshold reached with the enable on must raise the flag next edge
	property p_ovs_enter;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		ose_r[1] && !ovs_r[1] && (ao_lvl[15:8] >= ctaio_pkg::OVS_ENTER_PCT) |=> ovs_r[1];
	endproperty
	a_ovs_enter: assert property (p_ovs_enter) else $error("overscale not entered");

endmodule // ctaio_top

`default_nettype wire

// ---- ctaio_master_model.sv ----
// ctaio_master_model: behavioural logger or calibrator on the discrete inputs
// assumes the bench names the channels to request and their programmed polarity
`timescale 1ns/1ps
`default_nettype none
module ctaio_master_model (
	// clock
	input  wire logic       clk_in,
	// requests from the bench
	input  wire logic [7:0] req_in,      // 1 = ask for this channel's action
	input  wire logic [7:0] pol_high_in, // 1 = channel programmed active high
	input  wire logic       slow_in,     // 1 = answer one clock later
	// pins to the instrument
	output logic      [7:0] din_out
);
	logic [7:0] lvl_r = 8'h00; // pin levels, start low; idle at each channel's inactive level
	logic [7:0] dly_r = 8'h00; // delayed copy for a sluggish logger

	// active-low channels are pulled low to request, active-high ones high
	always @(posedge clk_in) begin
		lvl_r <= ~(req_in ^ pol_high_in);
		dly_r <= lvl_r;
	end

	// the slow path models a logger that settles a cycle late
	assign din_out = slow_in ? dly_r : lvl_r;
endmodule // ctaio_master_model
`default_nettype wire

// ---- ctaio_bench.sv ----
// ctaio_bench: self-checking bench of the trigger and alarm io block
// assumes ctaio_pkg, ctaio_top and ctaio_master_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module ctaio_bench;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        clk, rst, hsel, hwrite, hready, hresp, usb, bkg, slow;
	logic [31:0] haddr, hwdata, hrdata;
	logic [23:0] ao;       // analog levels, ch2..ch0
	logic [9:0]  flt;      // fault statuses
	logic [7:0]  din, dout, req, pol;
	logic [2:0]  hsize;
	logic [1:0]  htrans, cal;
	int          failures, n_checks;

	ctaio_top uut (.CLOCK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.FAULT_IN(flt), .USB_ABSENT_IN(usb), .BACKGROUND_IN(bkg), .AO_LEVEL_IN(ao),
		.DIN_IN(din), .DOUT_OUT(dout), .CAL_MODE_OUT(cal));
	// far-side logger drives the pins
	ctaio_master_model master (.clk_in(clk), .req_in(req), .pol_high_in(pol),
		.slow_in(slow), .din_out(din));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// bus and wait helpers
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		if (failures == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// bounded wait for hready; a hang ends the run
	task automatic wait_ready;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1) begin
			failures++;
			tally_and_finish();
		end
	endtask

	// one single word transfer; read data taken at the data phase edge
	task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		hwrite <= wr;
		haddr <= {24'h0, ofs};
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, ofs, d, x);
	endtask

	task automatic chk_reg(input string nm, input logic [7:0] ofs, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, ofs, 32'h0, v);
		`CHK(nm, e, v)
	endtask

	// mode changes take a few edges through the synchroniser
	task automatic wait_cal(input logic [1:0] e);
		int k;
		for (k = 0; k < 10 && cal !== e; k++) @(posedge clk);
		`CHK("cal mode", e, cal)
		if (cal !== e) tally_and_finish();
	endtask

	// raise exactly the status that selector c watches; -1 clears all, 20 sets all but the zero status
	task automatic set_stat(input int c);
		logic [31:0] ctl;
		flt <= (c == 20) ? 10'h3FF : (c == 15) ? 10'h020 :
			(c >= 1 && c <= 10) ? 10'h001 << (c - 1) : 10'h000;
		usb <= (c == 11 || c == 20);
		bkg <= (c == 12 || c == 20);
		ao <= (c == 20) ? 24'h5A5A5A : (c >= 17 && c <= 19) ? 24'h5A << (8 * (c - 17)) : 24'h0;
		ctl = (c == 13) ? 32'h1 : (c == 14) ? 32'h2 : (c == 16) ? 32'h4 : (c == 20) ? 32'h75 :
			(c >= 17 && c <= 19) ? 32'h10 << (c - 17) : 32'h0;
		wr(ctaio_pkg::OFS_CTRL, ctl);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic sc_reset_regs;
		`CHK("dout pins", 8'h00, dout)
		`CHK("cal mode", 2'h0, cal)
		chk_reg("input cfg", ctaio_pkg::OFS_DIN_CFG, 32'h4444_4444);
		chk_reg("out lo", ctaio_pkg::OFS_DOUT_LO, 32'h2020_2020);
		chk_reg("out hi", ctaio_pkg::OFS_DOUT_HI, 32'h2020_2020);
		chk_reg("ctrl", ctaio_pkg::OFS_CTRL, 32'h0);
		wr(ctaio_pkg::OFS_CTRL, 32'h1);
		wr(ctaio_pkg::OFS_CTRL, 32'h7);
		chk_reg("ctrl cal 3 kept", ctaio_pkg::OFS_CTRL, 32'h5);
		wr(ctaio_pkg::OFS_CTRL, 32'h0);
		wr(8'h20, 32'hFFFF_FFFF);
		chk_reg("unmapped", 8'h20, 32'h0);
		wr(ctaio_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		chk_reg("status", ctaio_pkg::OFS_STATUS, 32'h0);
	endtask

	// reset config, then the spare action code, leave every input idle
	task automatic sc_disabled_inputs;
		int i;
		for (i = 0; i < 2; i++) begin
			if (i == 1) wr(ctaio_pkg::OFS_DIN_CFG, 32'h7777_7777);
			req <= 8'hFF;
			repeat (8) @(posedge clk);
			`CHK("cal mode", 2'h0, cal)
			req <= 8'h00;
			repeat (4) @(posedge clk);
		end
	endtask

	// even channels span, odd zero; polarity mixed; later channels answer slowly
	task automatic sc_input_actions;
		logic [31:0] cfg;
		logic [31:0] v;
		int n;
		cfg = '0;
		for (n = 0; n < 8; n++) cfg[4*n +: 4] = {1'b0, n[1], n[0] ? 2'h2 : 2'h1};
		pol <= 8'hCC;
		repeat (3) @(posedge clk);
		wr(ctaio_pkg::OFS_DIN_CFG, cfg);
		for (n = 0; n < 8; n++) begin
			wr(ctaio_pkg::OFS_CTRL, 32'h0);
			slow <= n[2];
			req <= 8'h01 << n;
			wait_cal(n[0] ? 2'h2 : 2'h1);
			wr(ctaio_pkg::OFS_CTRL, 32'h0);
			repeat (6) @(posedge clk);
			`CHK("cal mode", 2'h0, cal)
			req <= 8'h00;
			repeat (6) @(posedge clk);
		end
		slow <= 1'b0;
		bus(1'b0, ctaio_pkg::OFS_STATUS, 32'h0, v);
		`CHK("status pins", 8'h33, v[7:0])
	endtask

	// every selector code on ch0 high, ch1 low, ch4 high
	task automatic sc_outputs;
		logic [31:0] v;
		int c;
		for (c = 0; c <= 20; c++) begin
			wr(ctaio_pkg::OFS_DOUT_LO, {16'h2020, 3'h0, c[4:0], 3'h1, c[4:0]});
			wr(ctaio_pkg::OFS_DOUT_HI, {24'h202020, 3'h1, c[4:0]});
			set_stat(-1);
			repeat (4) @(posedge clk);
			`CHK("dout idle", 8'h02, dout)
			set_stat(c);
			repeat (4) @(posedge clk);
			`CHK("dout busy", (c > 0 && c < 20) ? 8'h11 : 8'h02, dout)
			bus(1'b0, ctaio_pkg::OFS_STATUS, 32'h0, v);
			`CHK("summary", (c >= 1 && c <= 10) || c == 15 || c == 20, v[21])
			`CHK("status outs", (c > 0 && c < 20) ? 8'h11 : 8'h02, v[15:8])
			`CHK("st cal", (c == 13 || c == 20) ? 2'h1 : c == 14 ? 2'h2 : 2'h0, v[17:16])
		end
		set_stat(-1);
	endtask

	// hysteresis on analog output 1, watched on ch0
	task automatic sc_overscale;
		logic [7:0]  lv [6];
		logic [5:0]  ex;
		logic [31:0] v;
		int i;
		lv = '{8'h59, 8'h5A, 8'h55, 8'h51, 8'h50, 8'h59};
		ex = 6'b001110;
		wr(ctaio_pkg::OFS_DOUT_LO, 32'h2020_2032);
		wr(ctaio_pkg::OFS_CTRL, 32'h20);
		for (i = 0; i < 6; i++) begin
			ao <= {8'h00, lv[i], 8'h00};
			repeat (4) @(posedge clk);
			bus(1'b0, ctaio_pkg::OFS_STATUS, 32'h0, v);
			`CHK("overscale flag", ex[i], v[19])
			`CHK("overscale pin", ex[i], dout[0])
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst, hsel, hwrite, usb, bkg, slow} = 6'b100000;
		{haddr, hwdata, ao, flt, req} = '0;
		pol = 8'hFF;
		hsize = 3'h2;
		htrans = 2'h0;
		failures = 0;
		n_checks = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		sc_reset_regs();
		sc_disabled_inputs();
		sc_input_actions();
		sc_outputs();
		sc_overscale();
		tally_and_finish();
	end
endmodule // ctaio_bench
`default_nettype wire
